// file: shared/olc_pkg.sv
// Purpose: constants and carriers for the paged output limit command bank
// Assumes: one core clock, synchronous active-low reset
// Notes: register words are kept raw; no clamping on readback
`default_nettype none
package olc_pkg;
  localparam int CH_COUNT = 4;
  localparam int DATA_W = 16;
  localparam int DAC_W = 10;
  localparam int REG_COUNT = 16;
  localparam int SLOT_W = 4;
  // command codes
  localparam logic [7:0] CMD_FORMAT = 8'h20;
  localparam logic [7:0] CMD_SETPT = 8'h21;
  localparam logic [7:0] CMD_CEIL = 8'h24;
  localparam logic [7:0] CMD_MHI = 8'h25;
  localparam logic [7:0] CMD_MLO = 8'h26;
  localparam logic [7:0] CMD_SENSE_R = 8'h38;
  localparam logic [7:0] CMD_OVF = 8'h40;
  localparam logic [7:0] CMD_OVW = 8'h42;
  localparam logic [7:0] CMD_UVW = 8'h43;
  localparam logic [7:0] CMD_UVF = 8'h44;
  localparam logic [7:0] CMD_OCF = 8'h46;
  localparam logic [7:0] CMD_OCW = 8'h4a;
  localparam logic [7:0] CMD_RCF = 8'h4b;
  localparam logic [7:0] CMD_PG_ON = 8'h5e;
  localparam logic [7:0] CMD_PG_OFF = 8'h5f;
  localparam logic [7:0] CMD_DAC = 8'he0;
  localparam logic [7:0] CMD_COEF = 8'he9;
  localparam logic [7:0] CMD_TEMPCO = 8'hf6;
  // storage slots, in command order except tempco, which takes slot 8
  localparam logic [3:0] SL_SETPT = 4'h0;
  localparam logic [3:0] SL_CEIL = 4'h1;
  localparam logic [3:0] SL_MHI = 4'h2;
  localparam logic [3:0] SL_MLO = 4'h3;
  localparam logic [3:0] SL_UVF = 4'h9;
  localparam logic [3:0] SL_PG_ON = 4'hd;
  localparam logic [3:0] SL_PG_OFF = 4'he;
  localparam logic [3:0] SL_COEF = 4'hf;
  // format byte: linear mode 000b in [7:5], exponent -13 in [4:0]
  localparam logic [7:0] FMT_BYTE = 8'h13;
  localparam int L11_EXP_MSB = 15;
  localparam int L11_EXP_LSB = 11;
  localparam int L11_MANT_MSB = 10;
  localparam logic [1:0] DAC_MODE_HARD = 2'h2;
  localparam logic [1:0] DAC_MODE_SOFT = 2'h3;
  localparam int DAC_MODE_EN_BIT = 1;

  typedef enum logic [1:0] {CH_OFF, CH_DECAY, CH_ON} ch_state_t;
  typedef enum logic [1:0] {MRG_NOM, MRG_HIGH, MRG_LOW} margin_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] page;
    logic [7:0] code;
    logic [DATA_W-1:0] wdata;
  } cmd_req_t;

  typedef struct packed {
    logic en;
    logic rise_done;
    logic [1:0] dac_mode;
    margin_t margin;
    logic soft_done;
    logic [DAC_W-1:0] soft_code;
    logic [DATA_W-1:0] vout;
  } chan_in_t;

  typedef struct packed {
    logic on;
    logic dis_flag;
    logic pg;
    logic uv_low;
    logic dac_connect;
    logic [DAC_W-1:0] dac_code;
    logic [DATA_W-1:0] target;
  } chan_out_t;

  // {hit, slot} for every stored word
  function automatic logic [SLOT_W:0] slot_of(input logic [7:0] code);
    case (code)
      CMD_SETPT: slot_of = {1'b1, SL_SETPT};
      CMD_CEIL: slot_of = {1'b1, SL_CEIL};
      CMD_MHI: slot_of = {1'b1, SL_MHI};
      CMD_MLO: slot_of = {1'b1, SL_MLO};
      CMD_SENSE_R: slot_of = {1'b1, 4'h4};
      CMD_OVF: slot_of = {1'b1, 4'h5};
      CMD_OVW: slot_of = {1'b1, 4'h6};
      CMD_UVW: slot_of = {1'b1, 4'h7};
      CMD_UVF: slot_of = {1'b1, SL_UVF};
      CMD_OCF: slot_of = {1'b1, 4'ha};
      CMD_OCW: slot_of = {1'b1, 4'hb};
      CMD_RCF: slot_of = {1'b1, 4'hc};
      CMD_PG_ON: slot_of = {1'b1, SL_PG_ON};
      CMD_PG_OFF: slot_of = {1'b1, SL_PG_OFF};
      CMD_COEF: slot_of = {1'b1, SL_COEF};
      CMD_TEMPCO: slot_of = {1'b1, 4'h8};
      default: slot_of = '0;
    endcase
  endfunction : slot_of

  function automatic logic [DATA_W-1:0] reg_default(input logic [SLOT_W-1:0] s);
    case (s)
      4'h0: reg_default = 16'h2000;
      4'h1: reg_default = 16'h8000;
      4'h2: reg_default = 16'h219a;
      4'h3: reg_default = 16'h1e66;
      4'h4: reg_default = 16'hba00;
      4'h5: reg_default = 16'h2333;
      4'h6: reg_default = 16'h2266;
      4'h7: reg_default = 16'h1d9a;
      4'h9: reg_default = 16'h1ccd;
      4'ha: reg_default = 16'hd280;
      4'hb: reg_default = 16'hca80;
      4'hc: reg_default = 16'hb400;
      4'hd: reg_default = 16'h1eb8;
      4'he: reg_default = 16'h1e14;
      4'hf: reg_default = 16'hc200;
      default: reg_default = 16'h0000;
    endcase
  endfunction : reg_default
endpackage : olc_pkg
`default_nettype wire

// file: core/page_reg_store.sv
// Purpose: per-page word store with defaults on reset and a registered read port
// Assumes: one write and one read per cycle
// Notes: whole array is also visible so limit checks run on every page at once
`default_nettype none
module page_reg_store #(
  parameter int NCH = olc_pkg::CH_COUNT,
  parameter int NREG = olc_pkg::REG_COUNT
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic wr_en, // write strobe
  input wire logic [$clog2(NCH)-1:0] wr_page, // write page
  input wire logic [olc_pkg::SLOT_W-1:0] wr_slot, // write slot
  input wire logic [olc_pkg::DATA_W-1:0] wdata, // write word
  input wire logic [$clog2(NCH)-1:0] rd_page, // read page
  input wire logic [olc_pkg::SLOT_W-1:0] rd_slot, // read slot
  output logic [olc_pkg::DATA_W-1:0] rdata_r, // read word, one cycle later
  output logic [NCH-1:0][NREG-1:0][olc_pkg::DATA_W-1:0] all_q // every stored word
);
  typedef struct packed {
    logic [NCH-1:0][NREG-1:0][olc_pkg::DATA_W-1:0] mem;
    logic [olc_pkg::DATA_W-1:0] rdata;
  } store_t;
  store_t s_r;
  store_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    // raw word kept; consumers clamp on use, readback shows what was written
    if (wr_en) begin
      s_nxt.mem[wr_page][wr_slot] = wdata;
    end
    s_nxt.rdata = s_r.mem[rd_page][rd_slot];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int p = 0; p < NCH; p++) begin
        for (int r = 0; r < NREG; r++) begin
          s_r.mem[p][r] <= olc_pkg::reg_default(olc_pkg::SLOT_W'(r));
        end
      end
      s_r.rdata <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_r = s_r.rdata;
  assign all_q = s_r.mem;
endmodule : page_reg_store
`default_nettype wire

// file: core/output_limit_command_bank.sv
// Purpose: paged output voltage and current command bank with discharge check
// Assumes: command port and channel inputs come from logic on CLOCK
// Notes: read data appear two cycles after the read strobe
// Function
// - format byte is read-only; bits 7:5 read 000b for linear mode.
// - format byte bits 4:0 always read exponent minus thirteen.
// - all sixteen-bit output voltage words use that mode and exponent.
// - on-command before output decays below coefficient times setpoint sets discharge flag.
// - discharge failure also drives the active-low alert low.
// - channel stays out of on state until output decays below threshold.
// - coefficient above one disables the discharge check.
// - direct DAC write works only when on, rise done, mode 10b or 11b.
// - mode 10b hard-connects the DAC with the direct code.
// - mode 11b soft-connects; direct code then reads the joining code.
// - direct DAC writes are dropped in mode 00b or 01b.
// - direct DAC word has ten code bits; upper six read zero.
// - direct DAC code resets to zero, not restored from storage.
// - undervoltage fault limit drives turn-on-time check and power-good drop.
// - power good rises when output is at or above the rise level.
// - with config bit clear, power good falls at or below fall level.
// - ceiling caps the commanded output over setpoint and margins.
// - reverse current limit is meant to be negative; host programs it.
// - setpoint is the servo target, default one volt.
// - sense gain tempco is a stored word resetting to zero.
// - current limit and sense words read back as last written.
`default_nettype none
module output_limit_command_bank #(
  parameter int NCH = olc_pkg::CH_COUNT
) (
  input wire logic CLOCK, // core clock
  input wire logic RST_N, // synchronous reset, active low
  input wire olc_pkg::cmd_req_t CMD, // command strobe, page, code, data
  input wire olc_pkg::chan_in_t [NCH-1:0] CH_IN, // per-channel status
  input wire logic PG_OFF_FROM_UNDERVOLT, // power good drops on uv limit
  input wire logic FLAG_CLR, // clears discharge flags
  output logic [olc_pkg::DATA_W-1:0] RD_DATA, // read answer
  output logic RD_VALID, // read answer strobe
  output logic CMD_ERR, // unsupported command or page
  output logic ALERT_N, // alert, active low
  output olc_pkg::chan_out_t [NCH-1:0] CH_OUT // per-channel results
);
  localparam int PW = $clog2(NCH);
  localparam int DW = olc_pkg::DATA_W;
  localparam int PW_DW = 48;

  typedef struct packed {
    olc_pkg::ch_state_t [NCH-1:0] st;
    logic [NCH-1:0] soft_j;
    olc_pkg::chan_out_t [NCH-1:0] out;
    logic pend_v;
    logic pend_st;
    logic pend_err;
    logic [DW-1:0] pend_d;
    logic [DW-1:0] rd_data;
    logic rd_valid;
    logic cmd_err;
    logic alert_n;
  } state_t;
  state_t s_r;
  state_t s_nxt;

  logic [NCH-1:0][olc_pkg::REG_COUNT-1:0][DW-1:0] words;
  logic [DW-1:0] st_rdata;
  logic [olc_pkg::SLOT_W:0] dec;
  logic page_ok;
  logic is_fmt;
  logic is_dac;
  logic [PW-1:0] page;
  logic [NCH-1:0] chk_w;
  logic [NCH-1:0] below_w;
  logic [NCH-1:0] go_w;
  logic [NCH-1:0][DW-1:0] ceil_w;

  // L11 value above 1.0
  function automatic logic gt_one(input logic [DW-1:0] c);
    logic signed [PW_DW-1:0] m;
    logic signed [4:0] e;
    m = PW_DW'(signed'(c[olc_pkg::L11_MANT_MSB:0]));
    e = c[olc_pkg::L11_EXP_MSB:olc_pkg::L11_EXP_LSB];
    if (e >= 0) begin
      gt_one = (m <<< 5'(e)) > 1;
    end else begin
      gt_one = m > (PW_DW'(1) <<< 5'(-e));
    end
  endfunction : gt_one

  // output below coefficient (L11) times setpoint (L16)
  function automatic logic below_thr(input logic [DW-1:0] v, input logic [DW-1:0] s,
                                     input logic [DW-1:0] c);
    logic signed [PW_DW-1:0] m;
    logic signed [PW_DW-1:0] p;
    logic signed [PW_DW-1:0] vv;
    logic signed [4:0] e;
    m = PW_DW'(signed'(c[olc_pkg::L11_MANT_MSB:0]));
    e = c[olc_pkg::L11_EXP_MSB:olc_pkg::L11_EXP_LSB];
    p = m * $signed(PW_DW'(s));
    vv = $signed(PW_DW'(v));
    if (e >= 0) begin
      below_thr = vv < (p <<< 5'(e));
    end else begin
      below_thr = (vv <<< 5'(-e)) < p;
    end
  endfunction : below_thr

  assign dec = olc_pkg::slot_of(CMD.code);
  assign page_ok = CMD.page < NCH;
  assign page = CMD.page[PW-1:0];
  assign is_fmt = CMD.code == olc_pkg::CMD_FORMAT;
  assign is_dac = CMD.code == olc_pkg::CMD_DAC;

  page_reg_store #(
    .NCH(NCH),
    .NREG(olc_pkg::REG_COUNT)
  ) u_store (
    .clk(CLOCK),
    .rst_n(RST_N),
    .wr_en(CMD.wr && page_ok && dec[olc_pkg::SLOT_W]),
    .wr_page(page),
    .wr_slot(dec[olc_pkg::SLOT_W-1:0]),
    .wdata(CMD.wdata),
    .rd_page(page),
    .rd_slot(dec[olc_pkg::SLOT_W-1:0]),
    .rdata_r(st_rdata),
    .all_q(words)
  );

  // both words share the L16 exponent, so they compare as plain integers
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    assign ceil_w[i] = words[i][olc_pkg::SL_CEIL];
    assign chk_w[i] = !gt_one(words[i][olc_pkg::SL_COEF]);
    assign below_w[i] = below_thr(CH_IN[i].vout, words[i][olc_pkg::SL_SETPT],
                                  words[i][olc_pkg::SL_COEF]);
    assign go_w[i] = !chk_w[i] || below_w[i];
  end

  always_comb begin
    logic [DW-1:0] cmdv;
    logic [DW-1:0] off_lvl;
    logic [DW-1:0] uvf;
    logic dac_ok;
    cmdv = '0;
    off_lvl = '0;
    uvf = '0;
    dac_ok = 1'b0;
    s_nxt = s_r;
    s_nxt.rd_valid = 1'b0;
    s_nxt.cmd_err = 1'b0;
    // read stage 1: capture what the answer will be made of
    s_nxt.pend_v = CMD.rd;
    s_nxt.pend_st = dec[olc_pkg::SLOT_W];
    s_nxt.pend_err = !page_ok || !(dec[olc_pkg::SLOT_W] || is_fmt || is_dac);
    if (is_fmt) begin
      s_nxt.pend_d = {8'h00, olc_pkg::FMT_BYTE};
    end else if (is_dac && page_ok) begin
      s_nxt.pend_d = {6'h00, s_r.out[page].dac_code};
    end else begin
      s_nxt.pend_d = '0;
    end
    // read stage 2: store word has landed
    if (s_r.pend_v) begin
      s_nxt.rd_valid = 1'b1;
      s_nxt.cmd_err = s_r.pend_err;
      if (s_r.pend_err) begin
        s_nxt.rd_data = '0;
      end else if (s_r.pend_st) begin
        s_nxt.rd_data = st_rdata;
      end else begin
        s_nxt.rd_data = s_r.pend_d;
      end
    end
    // the format byte is read-only, so writing it is refused
    if (CMD.wr && (!page_ok || !(dec[olc_pkg::SLOT_W] || is_dac))) begin
      s_nxt.cmd_err = 1'b1;
    end

    for (int i = 0; i < NCH; i++) begin
      uvf = words[i][olc_pkg::SL_UVF];
      // on-request is a level; the flag fires once, on leaving off
      case (s_r.st[i])
        olc_pkg::CH_OFF: begin
          if (CH_IN[i].en) begin
            s_nxt.st[i] = go_w[i] ? olc_pkg::CH_ON : olc_pkg::CH_DECAY;
          end
        end
        olc_pkg::CH_DECAY: begin
          if (!CH_IN[i].en) begin
            s_nxt.st[i] = olc_pkg::CH_OFF;
          end else if (go_w[i]) begin
            s_nxt.st[i] = olc_pkg::CH_ON;
          end
        end
        olc_pkg::CH_ON: begin
          if (!CH_IN[i].en) begin
            s_nxt.st[i] = olc_pkg::CH_OFF;
          end
        end
        default: s_nxt.st[i] = olc_pkg::CH_OFF;
      endcase
      // a new failure in the clearing cycle survives
      s_nxt.out[i].dis_flag = (s_r.st[i] == olc_pkg::CH_OFF && CH_IN[i].en && !go_w[i])
                              || (s_r.out[i].dis_flag && !FLAG_CLR);
      s_nxt.out[i].on = s_nxt.st[i] == olc_pkg::CH_ON;

      case (CH_IN[i].margin)
        olc_pkg::MRG_HIGH: cmdv = words[i][olc_pkg::SL_MHI];
        olc_pkg::MRG_LOW: cmdv = words[i][olc_pkg::SL_MLO];
        default: cmdv = words[i][olc_pkg::SL_SETPT];
      endcase
      s_nxt.out[i].target = (cmdv > ceil_w[i]) ? ceil_w[i] : cmdv;

      off_lvl = PG_OFF_FROM_UNDERVOLT ? uvf : words[i][olc_pkg::SL_PG_OFF];
      if (CH_IN[i].vout >= words[i][olc_pkg::SL_PG_ON]) begin
        s_nxt.out[i].pg = 1'b1;
      end else if (CH_IN[i].vout <= off_lvl) begin
        s_nxt.out[i].pg = 1'b0;
      end
      s_nxt.out[i].uv_low = CH_IN[i].vout <= uvf;

      dac_ok = s_r.st[i] == olc_pkg::CH_ON && CH_IN[i].rise_done
               && CH_IN[i].dac_mode[olc_pkg::DAC_MODE_EN_BIT];
      if (CMD.wr && is_dac && page_ok && page == PW'(i) && dac_ok) begin
        s_nxt.out[i].dac_code = CMD.wdata[olc_pkg::DAC_W-1:0];
      end
      // soft join replaces the code with the one that met the supply
      if (CH_IN[i].dac_mode != olc_pkg::DAC_MODE_SOFT || !s_nxt.out[i].on) begin
        s_nxt.soft_j[i] = 1'b0;
      end else if (CH_IN[i].soft_done && !s_r.soft_j[i]) begin
        s_nxt.soft_j[i] = 1'b1;
        s_nxt.out[i].dac_code = CH_IN[i].soft_code;
      end
      s_nxt.out[i].dac_connect = s_nxt.out[i].on
          && (CH_IN[i].dac_mode == olc_pkg::DAC_MODE_HARD || s_nxt.soft_j[i]);
    end
    s_nxt.alert_n = 1'b1;
    for (int i = 0; i < NCH; i++) begin
      if (s_nxt.out[i].dis_flag) begin
        s_nxt.alert_n = 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      s_r <= '0;
      s_r.alert_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RD_DATA = s_r.rd_data;
  assign RD_VALID = s_r.rd_valid;
  assign CMD_ERR = s_r.cmd_err;
  assign ALERT_N = s_r.alert_n;
  assign CH_OUT = s_r.out;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  property p_fmt_mode;
    CMD.rd && is_fmt && page_ok |-> ##2 RD_VALID && RD_DATA[7:5] == 3'h0;
  endproperty
  a_fmt_mode: assert property (p_fmt_mode) else $error("format mode bits not zero");

  property p_fmt_exp;
    CMD.rd && is_fmt && page_ok |-> ##2 RD_DATA[4:0] == 5'h13 && !CMD_ERR;
  endproperty
  a_fmt_exp: assert property (p_fmt_exp) else $error("format exponent wrong");

  property p_flag_set;
    s_r.st[0] == olc_pkg::CH_OFF && CH_IN[0].en && chk_w[0] && !below_w[0]
      |=> CH_OUT[0].dis_flag && !CH_OUT[0].on;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("discharge flag missed");

  property p_alert;
    $rose(CH_OUT[0].dis_flag) |-> !ALERT_N;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not low on flag");

  property p_hold_off;
    $rose(CH_OUT[0].on) |-> $past(go_w[0]);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("turned on before decay");

  property p_no_check;
    s_r.st[0] == olc_pkg::CH_OFF && CH_IN[0].en && !chk_w[0]
      |=> CH_OUT[0].on && !$rose(CH_OUT[0].dis_flag);
  endproperty
  a_no_check: assert property (p_no_check) else $error("disabled check still held");

  property p_dac_drop;
    CMD.wr && is_dac && CMD.page == 8'h00 && !CH_IN[0].dac_mode[1]
      |=> $stable(CH_OUT[0].dac_code);
  endproperty
  a_dac_drop: assert property (p_dac_drop) else $error("dac write not dropped");

  property p_dac_read;
    CMD.rd && is_dac |-> ##2 RD_VALID && RD_DATA[15:10] == 6'h00;
  endproperty
  a_dac_read: assert property (p_dac_read) else $error("dac upper bits set");

  property p_ceiling;
    ##1 CH_OUT[0].target <= $past(ceil_w[0]);
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("target above ceiling");

  property p_pg_on;
    CH_IN[0].vout >= words[0][olc_pkg::SL_PG_ON] |=> CH_OUT[0].pg;
  endproperty
  a_pg_on: assert property (p_pg_on) else $error("power good not raised");

  // the rise level wins when both levels are met, so it is excluded here
  property p_pg_off;
    !PG_OFF_FROM_UNDERVOLT && CH_IN[0].vout <= words[0][olc_pkg::SL_PG_OFF]
      && CH_IN[0].vout < words[0][olc_pkg::SL_PG_ON]
      |=> !CH_OUT[0].pg;
  endproperty
  a_pg_off: assert property (p_pg_off) else $error("power good not dropped");

  property p_pg_uv;
    PG_OFF_FROM_UNDERVOLT && CH_IN[0].vout <= words[0][olc_pkg::SL_UVF]
      && CH_IN[0].vout < words[0][olc_pkg::SL_PG_ON]
      |=> !CH_OUT[0].pg && CH_OUT[0].uv_low;
  endproperty
  a_pg_uv: assert property (p_pg_uv) else $error("undervolt limit not applied");

  // soft mode excluded: a join may legally reload the code
  property p_dac_gate;
    CMD.wr && is_dac && CMD.page == 8'h00 && CH_IN[0].dac_mode != olc_pkg::DAC_MODE_SOFT
      && !(s_r.st[0] == olc_pkg::CH_ON && CH_IN[0].rise_done)
      |=> $stable(CH_OUT[0].dac_code);
  endproperty
  a_dac_gate: assert property (p_dac_gate) else $error("dac write not gated");

  property p_hard_conn;
    s_r.st[0] == olc_pkg::CH_ON && CH_IN[0].en
      && CH_IN[0].dac_mode == olc_pkg::DAC_MODE_HARD
      |=> CH_OUT[0].dac_connect;
  endproperty
  a_hard_conn: assert property (p_hard_conn) else $error("dac not hard connected");

  property p_setpt;
    CH_IN[0].margin == olc_pkg::MRG_NOM && words[0][olc_pkg::SL_SETPT] <= ceil_w[0]
      |=> CH_OUT[0].target == $past(words[0][olc_pkg::SL_SETPT]);
  endproperty
  a_setpt: assert property (p_setpt) else $error("target not setpoint");

  c_decay_wait: cover property (CH_OUT[0].dis_flag ##[1:50] $rose(CH_OUT[0].on));
  c_dac_write: cover property (CMD.wr && is_dac ##1 $changed(CH_OUT[0].dac_code));
  c_soft_join: cover property ($rose(s_r.soft_j[0]));
  c_pg_fall: cover property ($fell(CH_OUT[0].pg));
endmodule : output_limit_command_bank
`default_nettype wire

// file: dv/cmd_host.sv
// Purpose: host model issuing command reads and writes to the bank
// Assumes: requests launched on the falling edge, answers seen after rising edges
// Notes: one command in flight; err gathers any refusal seen in the answer window
`default_nettype none
module cmd_host (
  input wire logic CLOCK, // core clock
  output var olc_pkg::cmd_req_t CMD, // request to the bank
  input wire logic [olc_pkg::DATA_W-1:0] RD_DATA, // read answer
  input wire logic RD_VALID, // read answer strobe
  input wire logic CMD_ERR // refusal strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic err;
  int lat;
  logic [olc_pkg::DATA_W-1:0] rdata;

  initial CMD = '0;

  task automatic issue(input logic wr, input logic [7:0] page, input logic [7:0] code,
                       input logic [15:0] wdata);
    @(negedge CLOCK);
    CMD <= '{wr: wr, rd: !wr, page: page, code: code, wdata: wdata};
    err = 1'b0;
    lat = 0;
    rdata = '0;
    for (int i = 1; i <= 4; i++) begin
      @(negedge CLOCK);
      // idle fields show the inverse so a stale value is never mistaken for a request
      if (i == 1) CMD <= '{wr: 1'b0, rd: 1'b0, page: ~page, code: ~code, wdata: ~wdata};
      if (CMD_ERR === 1'b1) err = 1'b1;
      if (RD_VALID === 1'b1 && lat == 0) begin
        lat = i;
        rdata = RD_DATA;
      end
    end
  endtask : issue
endmodule : cmd_host
`default_nettype wire

// file: dv/tb_output_limit_command_bank.sv
// Purpose: directed test of the paged command bank through its command port
// Assumes: two channels, inputs changed on the falling edge
// Notes: channel 1 stays off, so its dac writes show the on-state gate
`default_nettype none
module tb_output_limit_command_bank;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int NCH = 2;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  olc_pkg::cmd_req_t cmd;
  olc_pkg::chan_in_t [NCH-1:0] ch_in;
  logic pg_uv = 1'b0;
  logic flag_clr = 1'b0;
  logic [15:0] rd_data;
  logic rd_valid;
  logic cmd_err;
  logic alert_n;
  olc_pkg::chan_out_t [NCH-1:0] ch_out;
  int bad_count = 0;
  int samples_checked = 0;
  logic [7:0] codes [18] = '{olc_pkg::CMD_FORMAT, olc_pkg::CMD_SETPT, olc_pkg::CMD_CEIL,
    olc_pkg::CMD_MHI, olc_pkg::CMD_MLO, olc_pkg::CMD_SENSE_R, olc_pkg::CMD_OVF,
    olc_pkg::CMD_OVW, olc_pkg::CMD_UVW, olc_pkg::CMD_UVF, olc_pkg::CMD_OCF,
    olc_pkg::CMD_OCW, olc_pkg::CMD_RCF, olc_pkg::CMD_PG_ON, olc_pkg::CMD_PG_OFF,
    olc_pkg::CMD_DAC, olc_pkg::CMD_COEF, olc_pkg::CMD_TEMPCO};
  logic [15:0] dflt [18] = '{16'h0013, 16'h2000, 16'h8000, 16'h219a, 16'h1e66, 16'hba00,
    16'h2333, 16'h2266, 16'h1d9a, 16'h1ccd, 16'hd280, 16'hca80, 16'hb400, 16'h1eb8,
    16'h1e14, 16'h0000, 16'hc200, 16'h0000};

  always #2 CLOCK = ~CLOCK;

  output_limit_command_bank #(.NCH(NCH)) output_limit_command_bank_inst (
    .CLOCK(CLOCK), .RST_N(RST_N), .CMD(cmd), .CH_IN(ch_in),
    .PG_OFF_FROM_UNDERVOLT(pg_uv), .FLAG_CLR(flag_clr), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .CMD_ERR(cmd_err), .ALERT_N(alert_n), .CH_OUT(ch_out));

  cmd_host cmd_host_inst (.CLOCK(CLOCK), .CMD(cmd), .RD_DATA(rd_data),
    .RD_VALID(rd_valid), .CMD_ERR(cmd_err));

  task automatic end_sim();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // a read is answered exactly two edges after it is taken
  task automatic rd(input logic [7:0] pg, input logic [7:0] code, input logic [15:0] exp,
                    input logic e);
    cmd_host_inst.issue(1'b0, pg, code, 16'h0000);
    chk(16'(cmd_host_inst.lat), 16'h0002);
    chk(cmd_host_inst.rdata, exp);
    chk(16'(cmd_host_inst.err), 16'(e));
  endtask : rd

  task automatic wr(input logic [7:0] pg, input logic [7:0] code, input logic [15:0] d,
                    input logic e);
    cmd_host_inst.issue(1'b1, pg, code, d);
    chk(16'(cmd_host_inst.err), 16'(e));
  endtask : wr

  task automatic cyc(input int n);
    repeat (n) @(negedge CLOCK);
  endtask : cyc

  initial begin
    #100000;
    bad_count++;
    end_sim();
  end

  initial begin
    ch_in = '0;
    ch_in[0].vout = 16'h2000;
    repeat (6) @(posedge CLOCK);
    @(negedge CLOCK);
    RST_N = 1'b1;
    for (int p = 0; p < NCH; p++) begin
      for (int i = 0; i < 18; i++) begin
        rd(8'(p), codes[i], dflt[i], 1'b0);
      end
    end
    wr(8'h00, olc_pkg::CMD_FORMAT, 16'h00ff, 1'b1);
    rd(8'h00, olc_pkg::CMD_FORMAT, 16'h0013, 1'b0);
    wr(8'h02, olc_pkg::CMD_SETPT, 16'h1000, 1'b1);
    rd(8'h02, olc_pkg::CMD_SETPT, 16'h0000, 1'b1);
    wr(8'h00, 8'h30, 16'h1234, 1'b1);
    // values beyond the internal clamps must read back untouched
    wr(8'h01, olc_pkg::CMD_SENSE_R, 16'hffff, 1'b0);
    rd(8'h01, olc_pkg::CMD_SENSE_R, 16'hffff, 1'b0);
    wr(8'h01, olc_pkg::CMD_OCF, 16'hc800, 1'b0);
    rd(8'h01, olc_pkg::CMD_OCF, 16'hc800, 1'b0);
    wr(8'h01, olc_pkg::CMD_RCF, 16'hbc00, 1'b0);
    rd(8'h01, olc_pkg::CMD_RCF, 16'hbc00, 1'b0);
    wr(8'h01, olc_pkg::CMD_TEMPCO, 16'h0f3c, 1'b0);
    rd(8'h01, olc_pkg::CMD_TEMPCO, 16'h0f3c, 1'b0);
    rd(8'h00, olc_pkg::CMD_SENSE_R, 16'hba00, 1'b0);
    chk(ch_out[0].target, 16'h2000);
    wr(8'h01, olc_pkg::CMD_CEIL, 16'h1000, 1'b0);
    cyc(2);
    chk(ch_out[1].target, 16'h1000);
    ch_in[1].margin = olc_pkg::MRG_HIGH;
    wr(8'h01, olc_pkg::CMD_CEIL, 16'h8000, 1'b0);
    cyc(2);
    chk(ch_out[1].target, 16'h219a);
    ch_in[1].margin = olc_pkg::MRG_LOW;
    cyc(2);
    chk(ch_out[1].target, 16'h1e66);
    // coefficient 0.5 puts the off threshold at 0x1000
    wr(8'h00, olc_pkg::CMD_COEF, 16'hf801, 1'b0);
    ch_in[0].en = 1'b1;
    cyc(2);
    chk(16'(ch_out[0].dis_flag), 16'h0001);
    chk(16'(alert_n), 16'h0000);
    cyc(4);
    chk(16'(ch_out[0].on), 16'h0000);
    ch_in[0].vout = 16'h0800;
    cyc(3);
    chk(16'(ch_out[0].on), 16'h0001);
    flag_clr = 1'b1;
    cyc(1);
    flag_clr = 1'b0;
    cyc(2);
    chk(16'(alert_n), 16'h0001);
    ch_in[0].en = 1'b0;
    wr(8'h00, olc_pkg::CMD_COEF, 16'hc200, 1'b0);
    chk(16'(ch_out[0].on), 16'h0000);
    ch_in[0].vout = 16'h2000;
    ch_in[0].en = 1'b1;
    cyc(3);
    chk(16'(ch_out[0].on), 16'h0001);
    chk(16'(ch_out[0].dis_flag), 16'h0000);
    ch_in[0].rise_done = 1'b1;
    for (int m = 0; m < 2; m++) begin
      ch_in[0].dac_mode = 2'(m);
      wr(8'h00, olc_pkg::CMD_DAC, 16'h0155, 1'b0);
      rd(8'h00, olc_pkg::CMD_DAC, 16'h0000, 1'b0);
    end
    ch_in[0].dac_mode = olc_pkg::DAC_MODE_HARD;
    ch_in[1].dac_mode = olc_pkg::DAC_MODE_HARD;
    ch_in[1].rise_done = 1'b1;
    ch_in[0].rise_done = 1'b0;
    wr(8'h00, olc_pkg::CMD_DAC, 16'h0155, 1'b0);
    rd(8'h00, olc_pkg::CMD_DAC, 16'h0000, 1'b0);
    wr(8'h01, olc_pkg::CMD_DAC, 16'h0155, 1'b0);
    rd(8'h01, olc_pkg::CMD_DAC, 16'h0000, 1'b0);
    ch_in[0].rise_done = 1'b1;
    wr(8'h00, olc_pkg::CMD_DAC, 16'hffff, 1'b0);
    rd(8'h00, olc_pkg::CMD_DAC, 16'h03ff, 1'b0);
    chk(16'(ch_out[0].dac_connect), 16'h0001);
    chk(16'(ch_out[0].dac_code), 16'h03ff);
    ch_in[0].dac_mode = olc_pkg::DAC_MODE_SOFT;
    ch_in[0].soft_code = 10'h0aa;
    cyc(1);
    chk(16'(ch_out[0].dac_connect), 16'h0000);
    ch_in[0].soft_done = 1'b1;
    cyc(1);
    ch_in[0].soft_done = 1'b0;
    cyc(2);
    rd(8'h00, olc_pkg::CMD_DAC, 16'h00aa, 1'b0);
    chk(16'(ch_out[0].dac_connect), 16'h0001);
    chk(16'(ch_out[0].pg), 16'h0001);
    ch_in[0].vout = 16'h1e14;
    cyc(2);
    chk(16'(ch_out[0].pg), 16'h0000);
    ch_in[0].vout = 16'h1eb7;
    cyc(2);
    chk(16'(ch_out[0].pg), 16'h0000);
    ch_in[0].vout = 16'h1eb8;
    cyc(2);
    chk(16'(ch_out[0].pg), 16'h0001);
    pg_uv = 1'b1;
    ch_in[0].vout = 16'h1e00;
    cyc(2);
    chk(16'(ch_out[0].pg), 16'h0001);
    chk(16'(ch_out[0].uv_low), 16'h0000);
    ch_in[0].vout = 16'h1c00;
    cyc(2);
    chk(16'(ch_out[0].pg), 16'h0000);
    chk(16'(ch_out[0].uv_low), 16'h0001);
    end_sim();
  end
endmodule : tb_output_limit_command_bank
`default_nettype wire
